// *** src/pmx_defines.svh ***
// shared constants for the peripheral pin mux and volume keys
`ifndef PMX_DEFINES_SVH
`define PMX_DEFINES_SVH
`define PMX_CLK_MHZ 200
`define PMX_DEBOUNCE_US 5
`define PMX_DEBOUNCE_CYC ((`PMX_DEBOUNCE_US * `PMX_CLK_MHZ))
`define PMX_REPEAT_MS 100
`define PMX_REPEAT_CYC ((`PMX_REPEAT_MS * 1000 * `PMX_CLK_MHZ))
`define PMX_ATTEN_W 4
`define PMX_ATTEN_MAX 4'h0F
`define PMX_ATTEN_MIN 4'h0
`define PMX_BUS_IDLE 8'h80
`define PMX_NUM_IRQ 16
`define PMX_NUM_DRQ 8
`endif

// *** src/pmx_pkg.sv ***
// types for the peripheral pin mux
package pmx_pkg;
   typedef enum logic [1:0] {PMX_SEL_CTL, PMX_SEL_ALT, PMX_SEL_KEY} pmx_fourfn_e;
   typedef enum {PMX_KEY_IDLE, PMX_KEY_HELD} pmx_key_e;
endpackage

// *** src/pmx_key_if.sv ***
// carrier between the main mux and one key debouncer
`timescale 1ns/1ps
interface pmx_key_if;
   logic rawLevel;
   logic enable;
   logic stepPulse;
   logic heldLevel;
   modport mux (output rawLevel, output enable, input stepPulse, input heldLevel);
   modport key (input rawLevel, input enable, output stepPulse, output heldLevel);
endinterface

// *** src/pmx_key_filter.sv ***
// synchroniser, debounce and repeat for one active-low key
`timescale 1ns/1ps
`include "pmx_defines.svh"
module pmx_key_filter
   import pmx_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYC = `PMX_DEBOUNCE_CYC,
   parameter int unsigned REPEAT_CYC = `PMX_REPEAT_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // key link
   pmx_key_if.key port
);
   logic [2:0] syncChain_reg;
   logic [31:0] bounceCnt_reg;
   logic [31:0] bounceCnt_next;
   logic [31:0] repCnt_reg;
   logic [31:0] repCnt_next;
   logic stable_reg;
   logic stable_next;
   pmx_key_e state_reg;
   pmx_key_e state_next;
   logic pulse_reg;
   logic pulse_next;
   wire logic agreeLow;
   wire logic settled;

   // three-stage synchroniser, stages two and three must agree
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) syncChain_reg <= 3'h7;
      else syncChain_reg <= {syncChain_reg[1:0], port.rawLevel};
   end
   assign agreeLow = (syncChain_reg[1] == syncChain_reg[2]) ? ~syncChain_reg[2] : stable_reg;

   // debounce: level must persist for the debounce time
   assign settled = (bounceCnt_reg >= DEBOUNCE_CYC - 1);
   always_comb begin
      bounceCnt_next = (agreeLow == stable_reg) ? 32'h0000_0000 : bounceCnt_reg + 32'h0000_0001;
      stable_next = stable_reg;
      if (agreeLow != stable_reg && settled) begin
         stable_next = agreeLow;
         bounceCnt_next = 32'h0000_0000;
      end
   end

   // step once per press, then once per repeat interval
   always_comb begin
      state_next = state_reg;
      repCnt_next = repCnt_reg;
      pulse_next = 1'b0;
      unique case (state_reg)
         PMX_KEY_IDLE: begin
            if (stable_reg && port.enable) begin
               state_next = PMX_KEY_HELD;
               pulse_next = 1'b1;
               repCnt_next = 32'h0000_0000;
            end
         end
         PMX_KEY_HELD: begin
            if (!stable_reg || !port.enable) begin
               state_next = PMX_KEY_IDLE;
            end else if (repCnt_reg >= REPEAT_CYC - 1) begin
               pulse_next = 1'b1;
               repCnt_next = 32'h0000_0000;
            end else begin
               repCnt_next = repCnt_reg + 32'h0000_0001;
            end
         end
      endcase
   end

   // state registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bounceCnt_reg <= 32'h0000_0000;
         repCnt_reg <= 32'h0000_0000;
         stable_reg <= 1'b0;
         state_reg <= PMX_KEY_IDLE;
         pulse_reg <= 1'b0;
      end else begin
         bounceCnt_reg <= bounceCnt_next;
         repCnt_reg <= repCnt_next;
         stable_reg <= stable_next;
         state_reg <= state_next;
         pulse_reg <= pulse_next;
      end
   end

   assign port.stepPulse = pulse_reg;
   assign port.heldLevel = stable_reg;
endmodule

// *** src/pmx_pin_mux.sv ***
// shared peripheral pin function select and hardware volume keys
//
// Function
// - serial enable turns joystick button into clock
// - drive pins are upper address unless strapped
// - drive select low on base address match
// - four-function pin shows control bit one unless write strap low
// - non-zero alternate base makes alternate select
// - volume key enable overrides other pin functions
// - drive interrupt routed with polarity, active high when polarity bit set
// - drive DMA request routed to chosen DRQ
// - modem base makes request pin modem interrupt
// - ack pin passes DACK or modem select
// - up key increments both master attenuations
// - down key decrements both master attenuations
// - mute key level sets both mute bits
// - reset drive high holds reset, bus reads 80h
// - reset falling edge latches both strobe straps
// - key enable by host or configuration byte
`timescale 1ns/1ps
`include "pmx_defines.svh"
module pmx_pin_mux
   import pmx_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYC = `PMX_DEBOUNCE_CYC,
   parameter int unsigned REPEAT_CYC = `PMX_REPEAT_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic resetDrive,
   // strap pins sampled at reset release
   input wire logic externalReadStrobeIn,
   input wire logic externalWriteStrobeIn,
   // configuration bits
   input wire logic serialPortEnableBit,
   input wire logic serialClock,
   input wire logic externalControlBitOne,
   input wire logic volumeKeyEnableHost,
   input wire logic volumeKeyEnableConfig,
   input wire logic driveIrqPolarityBit,
   input wire logic modemIrqPolarityBit,
   input wire logic [3:0] driveIrqSelect,
   input wire logic [3:0] modemIrqSelect,
   input wire logic [2:0] driveDrqSelect,
   // base address programming events
   input wire logic altBaseWrite,
   input wire logic [11:0] altBaseValue,
   input wire logic modemBaseWrite,
   input wire logic [11:0] modemBaseValue,
   // address decode results
   input wire logic driveDecodeHit,
   input wire logic altDecodeHit,
   input wire logic modemDecodeHit,
   input wire logic [3:0] isaUpperAddrIn,
   input wire logic isaDmaAckLow,
   // host bus read data
   input wire logic [7:0] coreReadData,
   output logic [7:0] busReadData,
   output logic coreResetActive,
   // shared pins
   input wire logic joyButtonTwoIn,
   output logic joyButtonTwoOut,
   output logic joyButtonTwoOe,
   output logic joyButtonTwoSwitch,
   input wire logic [3:0] drivePinsIn,
   output logic [3:0] upperAddr,
   output logic opticalDriveSelectLow,
   output logic drivePortEnabled,
   input wire logic fourFnPinIn,
   output logic fourFnPinOut,
   output logic fourFnPinOe,
   input wire logic synthSelPinIn,
   output logic synthSelPinOut,
   output logic synthSelPinOe,
   input wire logic synthSelectLow,
   input wire logic volumeMuteLow,
   input wire logic opticalDriveIrqIn,
   input wire logic dmaRequestPinIn,
   output logic opticalDriveDmaAckLow,
   // routed outputs to the ISA bus
   output logic [15:0] isaIrq,
   output logic [7:0] isaDrq,
   // master output register fields
   output logic [3:0] leftMasterAtten,
   output logic [3:0] rightMasterAtten,
   output logic leftMasterSilenceBit,
   output logic rightMasterSilenceBit
);
   // ----------------------------------------------------------------
   // reset drive and straps
   // ----------------------------------------------------------------
   logic [2:0] resSync_reg;
   logic resHeld;
   logic resHeldDly_reg;
   logic [2:0] rdSync_reg;
   logic [2:0] wrSync_reg;
   logic rdStrap_reg;
   logic wrStrap_reg;
   wire logic resFall;
   wire logic rdLevel;
   wire logic wrLevel;

   // synchronise reset drive and strap pins
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         resSync_reg <= 3'h7;
         rdSync_reg <= 3'h7;
         wrSync_reg <= 3'h7;
      end else begin
         resSync_reg <= {resSync_reg[1:0], resetDrive};
         rdSync_reg <= {rdSync_reg[1:0], externalReadStrobeIn};
         wrSync_reg <= {wrSync_reg[1:0], externalWriteStrobeIn};
      end
   end

   // reset drive level holds last value while stages disagree, strap levels taken from stage three
   logic resAgree_reg;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) resAgree_reg <= 1'b1;
      else if (resSync_reg[1] == resSync_reg[2]) resAgree_reg <= resSync_reg[2];
   end
   assign resHeld = resAgree_reg;
   assign rdLevel = rdSync_reg[2];
   assign wrLevel = wrSync_reg[2];
   assign resFall = resHeldDly_reg & ~resHeld;

   // latch straps on the reset drive falling edge
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         resHeldDly_reg <= 1'b1;
         rdStrap_reg <= 1'b1;
         wrStrap_reg <= 1'b1;
      end else begin
         resHeldDly_reg <= resHeld;
         if (resFall) begin
            rdStrap_reg <= rdLevel;
            wrStrap_reg <= wrLevel;
         end
      end
   end

   // bus interface stays alive, other logic held in reset
   assign coreResetActive = resHeld;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) busReadData <= `PMX_BUS_IDLE;
      else busReadData <= resHeld ? `PMX_BUS_IDLE : coreReadData;
   end

   // ----------------------------------------------------------------
   // sticky mode switches
   // ----------------------------------------------------------------
   logic altMode_reg;
   logic modemMode_reg;
   wire logic keysOn;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         altMode_reg <= 1'b0;
         modemMode_reg <= 1'b0;
      end else if (resHeld) begin
         altMode_reg <= 1'b0;
         modemMode_reg <= 1'b0;
      end else begin
         if (altBaseWrite && altBaseValue != 12'h000) altMode_reg <= 1'b1;
         if (modemBaseWrite && modemBaseValue != 12'h000) modemMode_reg <= 1'b1;
      end
   end
   assign keysOn = (volumeKeyEnableHost | volumeKeyEnableConfig) & ~resHeld;
   assign drivePortEnabled = ~rdStrap_reg;

   // ----------------------------------------------------------------
   // pin function selection
   // ----------------------------------------------------------------
   pmx_fourfn_e fourFnSel;
   assign fourFnSel = keysOn ? PMX_SEL_KEY : (altMode_reg ? PMX_SEL_ALT : PMX_SEL_CTL);

   // joystick button two or serial clock
   assign joyButtonTwoOe = serialPortEnableBit & ~keysOn;
   assign joyButtonTwoOut = serialClock;
   assign joyButtonTwoSwitch = joyButtonTwoOe ? 1'b1 : joyButtonTwoIn;

   // drive pins as upper address or drive port
   assign upperAddr = drivePortEnabled ? 4'h0 : drivePinsIn;
   assign opticalDriveSelectLow = ~(drivePortEnabled & driveDecodeHit & ~resHeld);

   // four-function pin: control bit, alternate select or down key
   // a low write strap turns the control bit output into an input
   assign fourFnPinOe = (fourFnSel == PMX_SEL_ALT) | ((fourFnSel == PMX_SEL_CTL) & wrStrap_reg);
   assign fourFnPinOut = (fourFnSel == PMX_SEL_ALT) ? ~altDecodeHit : externalControlBitOne;

   // synth select pin or up key
   assign synthSelPinOe = ~keysOn;
   assign synthSelPinOut = synthSelectLow;

   // ack pin: DACK pass or modem select
   assign opticalDriveDmaAckLow = modemMode_reg ? ~modemDecodeHit : isaDmaAckLow;

   // interrupt and DMA routing
   wire logic driveIrqActive;
   wire logic modemIrqActive;
   wire logic driveDrqActive;
   assign driveIrqActive = drivePortEnabled & (opticalDriveIrqIn ^ ~driveIrqPolarityBit);
   assign modemIrqActive = drivePortEnabled & modemMode_reg & (dmaRequestPinIn ^ ~modemIrqPolarityBit);
   assign driveDrqActive = drivePortEnabled & ~modemMode_reg & dmaRequestPinIn;

   genvar gi;
   generate
      for (gi = 0; gi < `PMX_NUM_IRQ; gi++) begin : g_irq
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) isaIrq[gi] <= 1'b0;
            else isaIrq[gi] <= ~resHeld & ((driveIrqActive & (driveIrqSelect == 4'(gi)))
                               | (modemIrqActive & (modemIrqSelect == 4'(gi))));
         end
      end
      for (gi = 0; gi < `PMX_NUM_DRQ; gi++) begin : g_drq
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) isaDrq[gi] <= 1'b0;
            else isaDrq[gi] <= ~resHeld & driveDrqActive & (driveDrqSelect == 3'(gi));
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // volume keys
   // ----------------------------------------------------------------
   pmx_key_if upKey();
   pmx_key_if downKey();
   pmx_key_if muteKey();
   assign upKey.rawLevel = synthSelPinIn;
   assign downKey.rawLevel = fourFnPinIn;
   assign muteKey.rawLevel = volumeMuteLow;
   assign upKey.enable = keysOn;
   assign downKey.enable = keysOn;
   assign muteKey.enable = keysOn;

   pmx_key_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .REPEAT_CYC(REPEAT_CYC)) uUp (
      .sys_clk(sys_clk), .nrst(nrst), .port(upKey));
   pmx_key_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .REPEAT_CYC(REPEAT_CYC)) uDown (
      .sys_clk(sys_clk), .nrst(nrst), .port(downKey));
   pmx_key_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .REPEAT_CYC(REPEAT_CYC)) uMute (
      .sys_clk(sys_clk), .nrst(nrst), .port(muteKey));

   // saturating step of one attenuation field
   function automatic logic [3:0] stepAtten(input logic [3:0] cur, input logic up, input logic dn);
      logic [3:0] res;
      res = cur;
      if (up && !dn && cur != `PMX_ATTEN_MAX) res = cur + 4'h1;
      else if (dn && !up && cur != `PMX_ATTEN_MIN) res = cur - 4'h1;
      return res;
   endfunction

   logic [3:0] leftAtten_reg;
   logic [3:0] rightAtten_reg;
   logic muteBits_reg;
   wire logic [3:0] leftAtten_next;
   wire logic [3:0] rightAtten_next;
   assign leftAtten_next = stepAtten(leftAtten_reg, upKey.stepPulse, downKey.stepPulse);
   assign rightAtten_next = stepAtten(rightAtten_reg, upKey.stepPulse, downKey.stepPulse);

   // master attenuation and mute fields
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         leftAtten_reg <= 4'h0;
         rightAtten_reg <= 4'h0;
         muteBits_reg <= 1'b0;
      end else if (resHeld) begin
         leftAtten_reg <= 4'h0;
         rightAtten_reg <= 4'h0;
         muteBits_reg <= 1'b0;
      end else begin
         leftAtten_reg <= leftAtten_next;
         rightAtten_reg <= rightAtten_next;
         muteBits_reg <= keysOn ? muteKey.heldLevel : muteBits_reg;
      end
   end
   assign leftMasterAtten = leftAtten_reg;
   assign rightMasterAtten = rightAtten_reg;
   assign leftMasterSilenceBit = muteBits_reg;
   assign rightMasterSilenceBit = muteBits_reg;
endmodule

// *** testbench/pmx_pin_mux_assertions.sv ***
// concurrent checks on the pin mux top-level ports
`timescale 1ns/1ps
module pmx_pin_mux_assertions #(
   parameter int unsigned DEBOUNCE_CYC = 4,
   parameter int unsigned REPEAT_CYC = 20
) (
   // clock, reset and controls
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic serialPortEnableBit,
   input wire logic serialClock,
   input wire logic volumeKeyEnableHost,
   input wire logic volumeKeyEnableConfig,
   input wire logic driveIrqPolarityBit,
   input wire logic [3:0] driveIrqSelect,
   input wire logic [3:0] modemIrqSelect,
   input wire logic driveDecodeHit,
   input wire logic volumeMuteLow,
   input wire logic opticalDriveIrqIn,
   input wire logic resetDrive,
   input wire logic [3:0] drivePinsIn,
   // observed outputs
   input wire logic [7:0] busReadData,
   input wire logic coreResetActive,
   input wire logic joyButtonTwoOut,
   input wire logic joyButtonTwoOe,
   input wire logic [3:0] upperAddr,
   input wire logic opticalDriveSelectLow,
   input wire logic drivePortEnabled,
   input wire logic fourFnPinOe,
   input wire logic synthSelPinOe,
   input wire logic [15:0] isaIrq,
   input wire logic [3:0] leftMasterAtten,
   input wire logic leftMasterSilenceBit,
   input wire logic rightMasterSilenceBit
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // keys on from either source, core running
   wire keysOn = volumeKeyEnableHost | volumeKeyEnableConfig;
   wire run = !coreResetActive;
   property p_serial; serialPortEnableBit && !keysOn && run |-> joyButtonTwoOe && joyButtonTwoOut == serialClock;
   endproperty
   a_serial: assert property (p_serial) else $error("serial clock not on joystick pin");
   property p_upper; !drivePortEnabled && run |-> upperAddr == drivePinsIn; endproperty
   a_upper: assert property (p_upper) else $error("upper address not passed");
   property p_select; drivePortEnabled && driveDecodeHit && run |-> !opticalDriveSelectLow; endproperty
   a_select: assert property (p_select) else $error("drive select not low on hit");
   property p_keyoe; keysOn && run |-> !fourFnPinOe && !synthSelPinOe && !joyButtonTwoOe; endproperty
   a_keyoe: assert property (p_keyoe) else $error("pin driven in key mode");
   property p_irq;
      drivePortEnabled && run && !resetDrive && driveIrqSelect != modemIrqSelect
      |=> isaIrq[$past(driveIrqSelect)] == ($past(opticalDriveIrqIn) == $past(driveIrqPolarityBit));
   endproperty
   a_irq: assert property (p_irq) else $error("drive interrupt misrouted");
   property p_mute;
      (keysOn && !volumeMuteLow && run)[*8] ##1 (keysOn && !volumeMuteLow && run)[*8]
      |=> leftMasterSilenceBit && rightMasterSilenceBit;
   endproperty
   a_mute: assert property (p_mute) else $error("mute bits not set");
   property p_step;
      run && !$stable(leftMasterAtten) |-> (leftMasterAtten == $past(leftMasterAtten) + 4'h1
         && $past(leftMasterAtten) != 4'hF) || (leftMasterAtten == $past(leftMasterAtten) - 4'h1
         && $past(leftMasterAtten) != 4'h0);
   endproperty
   a_step: assert property (p_step) else $error("attenuation jumped or wrapped");
   property p_idle; coreResetActive [*2] |-> busReadData == 8'h80; endproperty
   a_idle: assert property (p_idle) else $error("bus not idle in reset");
endmodule
bind pmx_pin_mux pmx_pin_mux_assertions #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .REPEAT_CYC(REPEAT_CYC)) chk (
   .sys_clk, .nrst, .serialPortEnableBit, .serialClock, .volumeKeyEnableHost, .volumeKeyEnableConfig,
   .driveIrqPolarityBit, .driveIrqSelect, .modemIrqSelect, .driveDecodeHit, .volumeMuteLow,
   .opticalDriveIrqIn, .resetDrive, .drivePinsIn, .busReadData, .coreResetActive, .joyButtonTwoOut,
   .joyButtonTwoOe, .upperAddr, .opticalDriveSelectLow, .drivePortEnabled, .fourFnPinOe, .synthSelPinOe,
   .isaIrq, .leftMasterAtten, .leftMasterSilenceBit, .rightMasterSilenceBit);

// *** testbench/pmx_far_model.sv ***
// far-side switches and optical drive request pins
`timescale 1ns/1ps
module pmx_far_model (
   // switch contacts, pulled up when open
   output logic upKeyLow,
   output logic downKeyLow,
   output logic muteKeyLow,
   // optical drive and modem request pins
   output logic driveIrq,
   output logic driveDrq
);
   // open switches rest at the pull-up level
   initial begin
      {muteKeyLow, downKeyLow, upKeyLow} = 3'b111;
      {driveIrq, driveDrq} = 2'b00;
   end
   // close the switches in the mask: bit0 up, bit1 down, bit2 mute
   task automatic set_keys(input logic [2:0] keys);
      {muteKeyLow, downKeyLow, upKeyLow} = ~keys;
   endtask
   // drive interrupt and request levels
   task automatic set_drive(input logic irq, input logic drq);
      {driveIrq, driveDrq} = {irq, drq};
   endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the pin mux and volume keys
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 1'b0, nrst = 1'b0, resetDrive = 1'b1, externalReadStrobeIn = 1'b1;
   logic externalWriteStrobeIn = 1'b1, joyButtonLow = 1'b1, synthSelectLow = 1'b1;
   logic serialPortEnableBit = 1'b0, serialClock = 1'b0, externalControlBitOne = 1'b0;
   logic volumeKeyEnableHost = 1'b0, volumeKeyEnableConfig = 1'b0;
   logic driveIrqPolarityBit = 1'b1, modemIrqPolarityBit = 1'b0;
   logic [3:0] driveIrqSelect = 4'h5, modemIrqSelect = 4'h3, drivePinsIn = 4'hA;
   logic [2:0] driveDrqSelect = 3'h0;
   logic altBaseWrite = 1'b0, modemBaseWrite = 1'b0;
   logic [11:0] altBaseValue = 12'h000, modemBaseValue = 12'h000;
   logic driveDecodeHit = 1'b0, altDecodeHit = 1'b0, modemDecodeHit = 1'b0, isaDmaAckLow = 1'b1;
   logic [7:0] coreReadData = 8'h5A, busReadData, isaDrq;
   logic upKeyLow, downKeyLow, muteKeyLow, driveIrq, driveDrq, coreResetActive;
   logic joyButtonTwoOut, joyButtonTwoOe, joyButtonTwoSwitch, opticalDriveSelectLow, drivePortEnabled;
   logic fourFnPinOut, fourFnPinOe, synthSelPinOut, synthSelPinOe, opticalDriveDmaAckLow;
   logic leftMasterSilenceBit, rightMasterSilenceBit;
   logic [3:0] upperAddr, leftMasterAtten, rightMasterAtten;
   logic [15:0] isaIrq;
   int nErrors = 0, numChecks = 0;
   // shared pins resolve between design and switches
   wire logic joyButtonTwoIn = joyButtonTwoOe ? joyButtonTwoOut : joyButtonLow;
   wire logic fourFnPinIn = fourFnPinOe ? fourFnPinOut : downKeyLow;
   wire logic synthSelPinIn = synthSelPinOe ? synthSelPinOut : upKeyLow;
   always #2.5 sys_clk = ~sys_clk;
   pmx_far_model far (.upKeyLow, .downKeyLow, .muteKeyLow, .driveIrq, .driveDrq);
   pmx_pin_mux #(.DEBOUNCE_CYC(4), .REPEAT_CYC(20)) dut (.sys_clk, .nrst, .resetDrive, .externalReadStrobeIn,
      .externalWriteStrobeIn, .serialPortEnableBit, .serialClock, .externalControlBitOne,
      .volumeKeyEnableHost, .volumeKeyEnableConfig, .driveIrqPolarityBit, .modemIrqPolarityBit,
      .driveIrqSelect, .modemIrqSelect, .driveDrqSelect, .altBaseWrite, .altBaseValue, .modemBaseWrite,
      .modemBaseValue, .driveDecodeHit, .altDecodeHit, .modemDecodeHit, .isaUpperAddrIn(4'h0), .isaDmaAckLow,
      .coreReadData, .busReadData, .coreResetActive, .joyButtonTwoIn, .joyButtonTwoOut, .joyButtonTwoOe,
      .joyButtonTwoSwitch, .drivePinsIn, .upperAddr, .opticalDriveSelectLow, .drivePortEnabled, .fourFnPinIn,
      .fourFnPinOut, .fourFnPinOe, .synthSelPinIn, .synthSelPinOut, .synthSelPinOe, .synthSelectLow,
      .volumeMuteLow(muteKeyLow), .opticalDriveIrqIn(driveIrq), .dmaRequestPinIn(driveDrq),
      .opticalDriveDmaAckLow, .isaIrq, .isaDrq, .leftMasterAtten, .rightMasterAtten, .leftMasterSilenceBit,
      .rightMasterSilenceBit);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      numChecks++;
      if (got !== exp) begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         nErrors++;
      end
   endtask
   // hold switches for n cycles, release and let repeats drain
   task automatic press(input logic [2:0] keys, input int n);
      far.set_keys(keys);
      step(n);
      far.set_keys(3'b000);
      step(40);
   endtask
   task automatic stopTest;
      if (nErrors == 0 && numChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog well beyond the expected 1300 or so cycles
   initial begin
      repeat (50000) @(posedge sys_clk);
      nErrors++;
      stopTest();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      step(20);
      nrst = 1'b1;
      step(6);
      check(16'({coreResetActive, busReadData}), 16'h0180);
      resetDrive = 1'b0;
      step(8);
      check(16'({coreResetActive, drivePortEnabled, busReadData}), 16'h005A);
      check(16'(upperAddr), 16'h000A);
      joyButtonLow = 1'b0;
      synthSelectLow = 1'b0;
      coreReadData = 8'hC3;
      step(1);
      check(16'({joyButtonTwoSwitch, synthSelPinOut, synthSelPinOe, busReadData}), 16'h01C3);
      synthSelectLow = 1'b1;
      serialPortEnableBit = 1'b1;
      serialClock = 1'b1;
      step(1);
      check(16'({joyButtonTwoOe, joyButtonTwoOut, joyButtonTwoSwitch}), 16'h0007);
      serialClock = 1'b0;
      externalControlBitOne = 1'b1;
      step(1);
      check(16'({joyButtonTwoOe, joyButtonTwoOut, fourFnPinOe, fourFnPinOut}), 16'h000B);
      // restrap with the read strobe held low
      resetDrive = 1'b1;
      externalReadStrobeIn = 1'b0;
      externalWriteStrobeIn = 1'b0;
      step(8);
      resetDrive = 1'b0;
      step(8);
      externalReadStrobeIn = 1'b1;
      externalWriteStrobeIn = 1'b1;
      driveDecodeHit = 1'b1;
      step(1);
      check(16'({drivePortEnabled, upperAddr, opticalDriveSelectLow, fourFnPinOe}), 16'h0040);
      driveDecodeHit = 1'b0;
      for (int p = 0; p < 4; p++) begin
         driveIrqPolarityBit = p[1];
         far.set_drive(p[0], 1'b0);
         step(3);
         check(16'(isaIrq[5]), 16'(p[0] == p[1]));
      end
      for (int i = 0; i < 8; i++) begin
         driveDrqSelect = 3'(i);
         far.set_drive(1'b0, 1'b1);
         step(3);
         check(16'(isaDrq), 16'(8'h01 << i));
      end
      isaDmaAckLow = 1'b0;
      modemBaseWrite = 1'b1;
      step(1);
      modemBaseWrite = 1'b0;
      step(2);
      check(16'({opticalDriveDmaAckLow, opticalDriveSelectLow}), 16'h0001);
      modemBaseValue = 12'h3F8;
      modemBaseWrite = 1'b1;
      step(1);
      modemBaseWrite = 1'b0;
      modemDecodeHit = 1'b1;
      isaDmaAckLow = 1'b1;
      altBaseValue = 12'h170;
      altBaseWrite = 1'b1;
      step(1);
      altBaseWrite = 1'b0;
      check(16'(opticalDriveDmaAckLow), 16'h0000);
      altDecodeHit = 1'b1;
      modemDecodeHit = 1'b0;
      step(2);
      check(16'({opticalDriveDmaAckLow, fourFnPinOut}), 16'h0002);
      altDecodeHit = 1'b0;
      step(1);
      check(16'(fourFnPinOut), 16'h0001);
      for (int p = 0; p < 4; p++) begin
         modemIrqPolarityBit = p[1];
         far.set_drive(1'b0, p[0]);
         step(3);
         check(16'(isaIrq[3]), 16'(p[0] == p[1]));
      end
      volumeKeyEnableHost = 1'b1;
      step(2);
      check(16'({fourFnPinOe, synthSelPinOe, joyButtonTwoOe}), 16'h0000);
      press(3'b001, 14);
      check(16'({leftMasterAtten, rightMasterAtten}), 16'h0011);
      press(3'b011, 60);
      check(16'({leftMasterAtten, rightMasterAtten}), 16'h0011);
      press(3'b001, 400);
      check(16'({leftMasterAtten, rightMasterAtten}), 16'h00FF);
      press(3'b010, 14);
      check(16'({leftMasterAtten, rightMasterAtten}), 16'h00EE);
      volumeKeyEnableHost = 1'b0;
      volumeKeyEnableConfig = 1'b1;
      press(3'b010, 400);
      check(16'({leftMasterAtten, rightMasterAtten}), 16'h0000);
      far.set_keys(3'b100);
      step(20);
      check(16'({leftMasterSilenceBit, rightMasterSilenceBit}), 16'h0003);
      far.set_keys(3'b000);
      step(20);
      check(16'({leftMasterSilenceBit, rightMasterSilenceBit}), 16'h0000);
      volumeKeyEnableConfig = 1'b0;
      press(3'b001, 14);
      check(16'({fourFnPinOe, leftMasterAtten}), 16'h0010);
      stopTest();
   end
endmodule
